// ---- rtl/scad_regs.svh ----
// register offsets, field positions and codes of the slot access and buffer command decoder
`ifndef SCAD_REGS_SVH
`define SCAD_REGS_SVH

// register byte offsets on the register bus
`define SCAD_OFF_CMD_TYPE 8'h00
`define SCAD_OFF_TRIB 8'h04
`define SCAD_OFF_ADDR_LO 8'h08
`define SCAD_OFF_ADDR_MID 8'h0C
`define SCAD_OFF_KEY 8'h10
`define SCAD_OFF_CNT_HI 8'h14
`define SCAD_OFF_GO 8'h18
`define SCAD_OFF_CTRL 8'h1C
`define SCAD_OFF_RESP_TYPE 8'h20
`define SCAD_OFF_RESP_TRIB 8'h24
`define SCAD_OFF_RESP_DATA 8'h28
`define SCAD_OFF_STATUS 8'h2C
`define SCAD_OFF_POOL_CNT 8'h30
`define SCAD_OFF_PRIV_CNT 8'h34
`define SCAD_OFF_TX_CNT 8'h38

// bit positions
`define SCAD_BIT_GO 0
`define SCAD_BIT_POOL_EN 0
`define SCAD_BIT_ACK 0
`define SCAD_BIT_RESP_VALID 8
`define SCAD_KEY_WR 7
`define SCAD_KEY_RC 6
`define SCAD_KEY_RD 5

// read-and-clear location windows
`define SCAD_TSS_RC_LO 5'h07
`define SCAD_TSS_RC_HI 5'h0F
`define SCAD_GSS_RC_LO 5'h0D
`define SCAD_GSS_RC_HI 5'h0F

// command and response type codes
`define SCAD_CMD_RX 3'h0
`define SCAD_CMD_TX 3'h4
`define SCAD_CMD_CTRL 3'h1
`define SCAD_RESP_CTRL 3'h1
`define SCAD_RESP_INFO 3'h2

// procedural error codes, all even
`define SCAD_ERR_BAD_RC 8'h02
`define SCAD_ERR_TX_ZERO 8'h04
`define SCAD_ERR_CNT_ZERO 8'h06
`define SCAD_ERR_MULTI_KEY 8'h08
`define SCAD_ERR_BAD_TRIB 8'h0A
`define SCAD_ERR_POOL_OFF 8'h0C
`define SCAD_ERR_BAD_TYPE 8'h0E

// bus answers
`define SCAD_RESP_OKAY 2'h0
`define SCAD_RESP_SLVERR 2'h2

`endif

// ---- rtl/scad_pkg.sv ----
// types shared by the slot access and buffer command decoder
package scad_pkg;

  typedef enum logic [0:0] {
    SCAD_IDLE,
    SCAD_DATA
  } scad_fsm_t;

  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] cmd_type;
    logic [7:0] trib;
    logic [7:0] addr_lo;
    logic [7:0] addr_mid;
    logic [7:0] key;
    logic [7:0] cnt_hi;
    logic pool_en;
    scad_fsm_t fsm;
    logic [7:0] slot_trib;
    logic [4:0] slot_loc;
    logic rc;
    logic resp_valid;
    logic [2:0] resp_type;
    logic [7:0] resp_trib;
    logic [15:0] resp_data;
    logic buf_valid;
    logic buf_tx;
    logic [7:0] buf_trib;
    logic [17:0] buf_addr;
    logic [13:0] buf_count;
    logic [15:0] pool_cnt;
    logic [15:0] priv_cnt;
    logic [15:0] tx_cnt;
  } scad_state_t;

endpackage

// ---- rtl/scad_mem_if.sv ----
// port bundle between the decoder and its status slot store
`timescale 1ns/10ps
`default_nettype none
interface scad_mem_if #(
  parameter int AW = 8
);
  logic we;
  logic [AW-1:0] waddr;
  logic [15:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [15:0] rdata;

  modport ctl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

// ---- rtl/scad_slot_mem.sv ----
// word store holding the global slot and every tributary slot
`timescale 1ns/10ps
`default_nettype none
module scad_slot_mem #(
  parameter int AW = 8
) (
  // clock
  input wire logic aclk,
  // access port
  scad_mem_if.mem m
);
  logic [15:0] mem_q [2**AW];

  // one write and one registered read per cycle; read data lags one edge
  always_ff @(posedge aclk) begin
    if (m.we) begin
      mem_q[m.waddr] <= m.wdata;
    end
    if (m.re) begin
      m.rdata <= mem_q[m.raddr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/scad_decoder.sv ----
// slot access and buffer command decoder with its register bus slave
// Operation
// [R01] key bit six reads then clears location
// [R02] read-and-clear outside counters gives procedural error
// [R03] tributary address selects slot, zero global
// [R04] read-and-clear returns contents in information response
// [R05] tributary counters at locations 07 to 17
// [R06] global counters at locations 15 to 17
// [R07] key bit five reads any location
// [R08] plain read answers with information response
// [R09] type 000 receive, 100 transmit buffer
// [R10] transmit buffer to tributary zero errors
// [R11] point-to-point host sends to tributary one
// [R12] receive to tributary zero adds pool buffer
// [R13] nonzero tributary receive allocates private buffer
// [R14] buffer address from three bytes, 18 bits
// [R15] character count fourteen bits from two bytes
// [R16] zero character count gives procedural error
// [R17] responses typed in bits zero to two
// [R18] errors reported through control responses
// [R19] slot data through information responses
// [R20] key bit seven writes two data bytes
// [R21] slot locations are sixteen-bit words
// [R22] host clears access bits for request keys
// [R23] several access bits set gives error
// [R24] errors carry offending command's tributary address
`timescale 1ns/10ps
`default_nettype none
`include "scad_regs.svh"
module scad_decoder
  import scad_pkg::*;
#(
  parameter int TRIB_W = 3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // buffer allocation strobe towards the line side
  output logic buf_valid,
  output logic buf_tx,
  output logic [7:0] buf_trib,
  output logic [17:0] buf_addr,
  output logic [13:0] buf_count
);
  localparam int MAW = TRIB_W + 5;

  scad_state_t s_q;
  scad_state_t s_d;
  logic go_fire;
  logic [MAW-1:0] cmd_slot;
  scad_mem_if #(.AW(MAW)) mif ();

  scad_slot_mem #(.AW(MAW)) u_mem (
    .aclk(aclk),
    .m(mif)
  );

  // counter windows differ between the global and tributary slots
  function automatic logic rc_loc_ok(input logic [7:0] trib, input logic [4:0] loc);
    if (trib == 8'h00) begin
      rc_loc_ok = (loc >= `SCAD_GSS_RC_LO) && (loc <= `SCAD_GSS_RC_HI); // R06
    end else begin
      rc_loc_ok = (loc >= `SCAD_TSS_RC_LO) && (loc <= `SCAD_TSS_RC_HI); // R05
    end
  endfunction

  // register read decode; bit 32 flags an unmapped offset
  function automatic logic [32:0] read_word(input logic [7:0] a, input scad_state_t s);
    read_word = '0;
    unique case (a)
      `SCAD_OFF_CMD_TYPE: read_word[7:0] = s.cmd_type;
      `SCAD_OFF_TRIB: read_word[7:0] = s.trib;
      `SCAD_OFF_ADDR_LO: read_word[7:0] = s.addr_lo;
      `SCAD_OFF_ADDR_MID: read_word[7:0] = s.addr_mid;
      `SCAD_OFF_KEY: read_word[7:0] = s.key;
      `SCAD_OFF_CNT_HI: read_word[7:0] = s.cnt_hi;
      `SCAD_OFF_GO: read_word[`SCAD_BIT_GO] = (s.fsm != SCAD_IDLE);
      `SCAD_OFF_CTRL: read_word[`SCAD_BIT_POOL_EN] = s.pool_en;
      `SCAD_OFF_RESP_TYPE: begin
        read_word[2:0] = s.resp_type;
        read_word[`SCAD_BIT_RESP_VALID] = s.resp_valid;
      end
      `SCAD_OFF_RESP_TRIB: read_word[7:0] = s.resp_trib;
      `SCAD_OFF_RESP_DATA: read_word[15:0] = s.resp_data;
      `SCAD_OFF_STATUS: read_word[1:0] = {s.resp_valid, s.fsm != SCAD_IDLE};
      `SCAD_OFF_POOL_CNT: read_word[15:0] = s.pool_cnt;
      `SCAD_OFF_PRIV_CNT: read_word[15:0] = s.priv_cnt;
      `SCAD_OFF_TX_CNT: read_word[15:0] = s.tx_cnt;
      default: read_word[32] = 1'b1;
    endcase
  endfunction

  // slot index of the command in the registers: tributary above location
  assign cmd_slot = {s_q.trib[TRIB_W-1:0], s_q.key[4:0]}; // R03

  // handshake outputs
  assign awready = !s_q.aw_have;
  assign wready = !s_q.w_have;
  assign arready = !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign buf_valid = s_q.buf_valid;
  assign buf_tx = s_q.buf_tx;
  assign buf_trib = s_q.buf_trib;
  assign buf_addr = s_q.buf_addr;
  assign buf_count = s_q.buf_count;

  // next state of bus slave, command decode and response holding
  always_comb begin
    logic [32:0] rw;
    logic [7:0] err;
    logic [2:0] kind;
    logic [13:0] count;
    logic go;
    logic ack;
    logic [32:0] ww;
    rw = '0;
    // decode of the held write offset; a select on a call result is not legal
    ww = read_word(s_q.awaddr, s_q);
    err = 8'h00;
    go = 1'b0;
    ack = 1'b0;
    kind = s_q.key[`SCAD_KEY_WR:`SCAD_KEY_RD];
    count = {s_q.cnt_hi[5:0], s_q.key}; // R15
    s_d = s_q;
    s_d.buf_valid = 1'b0;
    mif.we = 1'b0;
    mif.waddr = cmd_slot;
    mif.wdata = {s_q.addr_mid, s_q.addr_lo}; // R21
    mif.re = 1'b0;
    mif.raddr = cmd_slot;
    // address and data are taken in either order and held until both are here
    if (awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.wdata = wdata[7:0];
      s_d.wstrb0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `SCAD_RESP_OKAY;
      // every field lives in the low byte, so only lane zero matters
      if (s_q.wstrb0) begin
        unique case (s_q.awaddr)
          `SCAD_OFF_CMD_TYPE: s_d.cmd_type = s_q.wdata;
          `SCAD_OFF_TRIB: s_d.trib = s_q.wdata;
          `SCAD_OFF_ADDR_LO: s_d.addr_lo = s_q.wdata;
          `SCAD_OFF_ADDR_MID: s_d.addr_mid = s_q.wdata;
          `SCAD_OFF_KEY: s_d.key = s_q.wdata;
          `SCAD_OFF_CNT_HI: s_d.cnt_hi = s_q.wdata;
          `SCAD_OFF_GO: go = s_q.wdata[`SCAD_BIT_GO];
          `SCAD_OFF_CTRL: s_d.pool_en = s_q.wdata[`SCAD_BIT_POOL_EN];
          `SCAD_OFF_RESP_TYPE: ack = s_q.wdata[`SCAD_BIT_ACK];
          default: s_d.bresp = ww[32] ? `SCAD_RESP_SLVERR : `SCAD_RESP_OKAY;
        endcase
      end else if (ww[32]) begin
        s_d.bresp = `SCAD_RESP_SLVERR;
      end
    end
    // register read answers at the same edge that takes the address
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && !s_q.rvalid) begin
      rw = read_word(araddr, s_q);
      s_d.rvalid = 1'b1;
      s_d.rdata = rw[31:0];
      s_d.rresp = rw[32] ? `SCAD_RESP_SLVERR : `SCAD_RESP_OKAY;
    end
    // acknowledge first, so a response landing in the same cycle survives
    if (ack) begin
      s_d.resp_valid = 1'b0;
    end
    // a command is refused while busy or while the last answer is unread
    go_fire = go && (s_q.fsm == SCAD_IDLE) && !s_q.resp_valid;
    unique case (s_q.fsm)
      SCAD_IDLE: begin
        if (go_fire) begin
          if (s_q.cmd_type[2:0] == `SCAD_CMD_RX || s_q.cmd_type[2:0] == `SCAD_CMD_TX) begin // R09
            if (count == 14'h0000) begin
              err = `SCAD_ERR_CNT_ZERO; // R16
            end else if (s_q.cmd_type[2:0] == `SCAD_CMD_TX && s_q.trib == 8'h00) begin
              err = `SCAD_ERR_TX_ZERO; // R10
            end else if (s_q.cmd_type[2:0] == `SCAD_CMD_RX && s_q.trib == 8'h00
                         && !s_q.pool_en) begin
              err = `SCAD_ERR_POOL_OFF; // R12
            end else begin
              s_d.buf_valid = 1'b1;
              s_d.buf_tx = (s_q.cmd_type[2:0] == `SCAD_CMD_TX);
              s_d.buf_trib = s_q.trib;
              s_d.buf_addr = {s_q.cnt_hi[7:6], s_q.addr_mid, s_q.addr_lo}; // R14
              s_d.buf_count = count; // R15
              if (s_q.cmd_type[2:0] == `SCAD_CMD_TX) begin
                s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
              end else if (s_q.trib == 8'h00) begin
                s_d.pool_cnt = s_q.pool_cnt + 16'h0001; // R12
              end else begin
                s_d.priv_cnt = s_q.priv_cnt + 16'h0001; // R13
              end
            end
          end else if (s_q.cmd_type[2:0] == `SCAD_CMD_CTRL) begin
            if (kind != 3'h0 && kind != 3'h4 && kind != 3'h2 && kind != 3'h1) begin
              err = `SCAD_ERR_MULTI_KEY; // R23
            end else if (kind != 3'h0 && (s_q.trib >> TRIB_W) != 8'h00) begin
              err = `SCAD_ERR_BAD_TRIB;
            end else if (kind[2]) begin
              mif.we = 1'b1; // R20
            end else if (kind[1] && !rc_loc_ok(s_q.trib, s_q.key[4:0])) begin
              err = `SCAD_ERR_BAD_RC; // R02
            end else if (kind != 3'h0) begin
              mif.re = 1'b1; // R07
              s_d.rc = kind[1]; // R01
              s_d.slot_trib = s_q.trib;
              s_d.slot_loc = s_q.key[4:0];
              s_d.fsm = SCAD_DATA;
            end
            // with no access bit the low field is a request key, handled elsewhere
          end else begin
            err = `SCAD_ERR_BAD_TYPE;
          end
          if (err != 8'h00) begin
            s_d.resp_valid = 1'b1;
            s_d.resp_type = `SCAD_RESP_CTRL; // R18
            s_d.resp_trib = s_q.trib; // R24
            s_d.resp_data = {8'h00, err};
          end
        end
      end
      SCAD_DATA: begin
        // slot word is on the read port now; answer with it, then clear if asked
        s_d.resp_valid = 1'b1;
        s_d.resp_type = `SCAD_RESP_INFO; // R04 R08 R17 R19
        s_d.resp_trib = s_q.slot_trib;
        s_d.resp_data = mif.rdata;
        mif.waddr = {s_q.slot_trib[TRIB_W-1:0], s_q.slot_loc};
        mif.wdata = 16'h0000;
        mif.we = s_q.rc; // R01
        s_d.fsm = SCAD_IDLE;
      end
    endcase
  end

  // the whole block state in one register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a bad read-and-clear location is answered by a control response
  rc_bad_err_a: assert property ( // R02
    go_fire && s_q.cmd_type[2:0] == `SCAD_CMD_CTRL && s_q.key[7:5] == 3'h2
    && (s_q.trib >> TRIB_W) == 8'h00 && !rc_loc_ok(s_q.trib, s_q.key[4:0])
    |=> s_q.resp_valid && s_q.resp_type == `SCAD_RESP_CTRL
    && s_q.resp_data == {8'h00, `SCAD_ERR_BAD_RC} && s_q.resp_trib == $past(s_q.trib))
    else $error("bad read-and-clear location not rejected");

  tx_zero_err_a: assert property ( // R10
    go_fire && s_q.cmd_type[2:0] == `SCAD_CMD_TX && s_q.trib == 8'h00
    && {s_q.cnt_hi[5:0], s_q.key} != 14'h0000
    |=> s_q.resp_valid && s_q.resp_data[7:0] == `SCAD_ERR_TX_ZERO && !s_q.buf_valid)
    else $error("transmit buffer to tributary zero accepted");

  cnt_zero_err_a: assert property ( // R16
    go_fire && (s_q.cmd_type[2:0] == `SCAD_CMD_RX || s_q.cmd_type[2:0] == `SCAD_CMD_TX)
    && {s_q.cnt_hi[5:0], s_q.key} == 14'h0000
    |=> s_q.resp_type == `SCAD_RESP_CTRL && s_q.resp_data[7:0] == `SCAD_ERR_CNT_ZERO)
    else $error("zero character count accepted");

  multi_key_err_a: assert property ( // R23
    go_fire && s_q.cmd_type[2:0] == `SCAD_CMD_CTRL && $countones(s_q.key[7:5]) > 1
    |=> s_q.resp_data[7:0] == `SCAD_ERR_MULTI_KEY ##1 s_q.fsm == SCAD_IDLE)
    else $error("several access bits not rejected");

  rc_clear_a: assert property ( // R01
    s_q.fsm == SCAD_DATA && s_q.rc |-> mif.we && mif.wdata == 16'h0000
    && mif.waddr == $past(cmd_slot))
    else $error("read-and-clear location not cleared");

  info_resp_a: assert property ( // R08
    go_fire && s_q.cmd_type[2:0] == `SCAD_CMD_CTRL && (s_q.key[7:5] == 3'h1)
    && (s_q.trib >> TRIB_W) == 8'h00
    |=> s_q.fsm == SCAD_DATA ##1 s_q.resp_valid && s_q.resp_type == `SCAD_RESP_INFO
    && s_q.resp_data == $past(mif.rdata))
    else $error("slot read not answered with information response");

  pool_add_a: assert property ( // R12
    go_fire && s_q.cmd_type[2:0] == `SCAD_CMD_RX && s_q.trib == 8'h00 && s_q.pool_en
    && {s_q.cnt_hi[5:0], s_q.key} != 14'h0000
    |=> s_q.pool_cnt == $past(s_q.pool_cnt) + 16'h0001 && s_q.priv_cnt == $past(s_q.priv_cnt))
    else $error("pool buffer not counted once");

  buf_fields_a: assert property ( // R14
    s_q.buf_valid |-> s_q.buf_addr == {$past(s_q.cnt_hi[7:6]), $past(s_q.addr_mid),
    $past(s_q.addr_lo)} && s_q.buf_count == {$past(s_q.cnt_hi[5:0]), $past(s_q.key)})
    else $error("buffer address or count assembled wrongly");

  slot_write_a: assert property ( // R20
    go_fire && s_q.cmd_type[2:0] == `SCAD_CMD_CTRL && s_q.key[7:5] == 3'h4
    && (s_q.trib >> TRIB_W) == 8'h00
    |-> mif.we && mif.wdata == {s_q.addr_mid, s_q.addr_lo} ##1 !s_q.resp_valid)
    else $error("slot write not performed");

  priv_buf_a: assert property ( // R13
    s_q.buf_valid && !s_q.buf_tx && s_q.buf_trib != 8'h00
    |-> s_q.priv_cnt == $past(s_q.priv_cnt) + 16'h0001)
    else $error("private buffer not counted");

  rc_seen_c: cover property (s_q.fsm == SCAD_DATA && s_q.rc);
  rd_seen_c: cover property (s_q.fsm == SCAD_DATA && !s_q.rc);
  tx_buf_c: cover property (s_q.buf_valid && s_q.buf_tx);
  err_resp_c: cover property (s_q.resp_valid && s_q.resp_type == `SCAD_RESP_CTRL);
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the slot access and buffer command decoder
`timescale 1ns/10ps
`default_nettype none
`include "scad_regs.svh"
module tb_top;
  // clock, reset and bus signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, arready, bvalid, rvalid, buf_valid, buf_tx;
  logic [1:0] bresp, rresp, last_bresp, last_rresp;
  logic [31:0] rdata;
  logic [7:0] buf_trib;
  logic [17:0] buf_addr;
  logic [13:0] buf_count;
  int err_total, comparisons, pulses;

  scad_decoder scad_decoder_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .buf_valid(buf_valid), .buf_tx(buf_tx), .buf_trib(buf_trib),
    .buf_addr(buf_addr), .buf_count(buf_count));

  // free-running 20 MHz clock
  always #25 aclk = ~aclk;

  // count allocation pulses; the pulse stands one cycle only
  always @(posedge aclk) begin
    if (buf_valid === 1'b1) pulses++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // ready is looked at on the falling edge so the rising edge never races the design
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ad, wd, tb;
    ad = 1'b0;
    wd = 1'b0;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    while (!tb) begin
      @(negedge aclk);
      tb = bvalid;
      last_bresp = bresp;
      @(posedge aclk);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic t;
    t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      last_rresp = rresp;
      @(posedge aclk);
    end
  endtask

  // load every command byte, then start it
  task automatic cmd(input logic [7:0] ty, tr, lo, mid, key, hi);
    wr(`SCAD_OFF_CMD_TYPE, {24'h00_0000, ty});
    wr(`SCAD_OFF_TRIB, {24'h00_0000, tr});
    wr(`SCAD_OFF_ADDR_LO, {24'h00_0000, lo});
    wr(`SCAD_OFF_ADDR_MID, {24'h00_0000, mid});
    wr(`SCAD_OFF_KEY, {24'h00_0000, key});
    wr(`SCAD_OFF_CNT_HI, {24'h00_0000, hi});
    wr(`SCAD_OFF_GO, 32'h0000_0001);
  endtask

  // wait for a response, judge it, then acknowledge so the next command is accepted
  task automatic resp(input logic [2:0] ty, input logic [7:0] tr, input logic [15:0] dat);
    logic [31:0] v;
    int n;
    v = 32'h0000_0000;
    n = 0;
    while (v[`SCAD_BIT_RESP_VALID] !== 1'b1 && n < 20) begin
      rd(`SCAD_OFF_RESP_TYPE, v);
      n++;
    end
    chk(v[8:0], {1'b1, 5'h00, ty});
    rd(`SCAD_OFF_RESP_TRIB, v);
    chk(v[7:0], tr);
    rd(`SCAD_OFF_RESP_DATA, v);
    chk(v[15:0], dat);
    wr(`SCAD_OFF_RESP_TYPE, 32'h0000_0001);
  endtask

  task automatic no_resp();
    logic [31:0] v;
    rd(`SCAD_OFF_STATUS, v);
    chk(v[1], 1'b0);
  endtask

  task automatic t_reset();
    logic [31:0] v;
    for (int a = 0; a <= 8'h38; a += 4) begin
      rd(8'(a), v);
      chk(v, 32'h0000_0000);
      chk(last_rresp, `SCAD_RESP_OKAY);
    end
    rd(8'h3C, v);
    chk(last_rresp, `SCAD_RESP_SLVERR);
    wr(8'h3C, 32'h0000_00FF);
    chk(last_bresp, `SCAD_RESP_SLVERR);
    wr(`SCAD_OFF_RESP_TRIB, 32'h0000_00FF);
    rd(`SCAD_OFF_RESP_TRIB, v);
    chk({last_bresp, v[7:0]}, 10'h000);
  endtask

  task automatic t_slot();
    logic [7:0] tr[4] = '{8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0] lc[4] = '{8'h07, 8'h0F, 8'h0D, 8'h0F};
    logic [7:0] bl[4] = '{8'h06, 8'h10, 8'h0C, 8'h07};
    cmd(8'h01, 8'h02, 8'hCD, 8'hAB, 8'h9F, 8'h00);
    no_resp();
    cmd(8'h01, 8'h00, 8'h34, 8'h12, 8'h9F, 8'h00);
    cmd(8'h01, 8'h02, 8'h00, 8'h00, 8'h3F, 8'h00);
    resp(`SCAD_RESP_INFO, 8'h02, 16'hABCD);
    cmd(8'h01, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00);
    resp(`SCAD_RESP_INFO, 8'h00, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h01, tr[i], lc[i], 8'h5A, 8'h80 | lc[i], 8'h00);
      cmd(8'h01, tr[i], 8'h00, 8'h00, 8'h40 | lc[i], 8'h00);
      resp(`SCAD_RESP_INFO, tr[i], {8'h5A, lc[i]});
      cmd(8'h01, tr[i], 8'h00, 8'h00, 8'h20 | lc[i], 8'h00);
      resp(`SCAD_RESP_INFO, tr[i], 16'h0000);
      cmd(8'h01, tr[i], 8'h00, 8'h00, 8'h40 | bl[i], 8'h00);
      resp(`SCAD_RESP_CTRL, tr[i], {8'h00, `SCAD_ERR_BAD_RC});
    end
  endtask

  task automatic t_keys();
    cmd(8'h01, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00);
    resp(`SCAD_RESP_CTRL, 8'h01, {8'h00, `SCAD_ERR_MULTI_KEY});
    cmd(8'h01, 8'h03, 8'h00, 8'h00, 8'hC5, 8'h00);
    resp(`SCAD_RESP_CTRL, 8'h03, {8'h00, `SCAD_ERR_MULTI_KEY});
    cmd(8'h01, 8'h08, 8'h00, 8'h00, 8'h20, 8'h00);
    resp(`SCAD_RESP_CTRL, 8'h08, {8'h00, `SCAD_ERR_BAD_TRIB});
    cmd(8'h01, 8'h01, 8'h00, 8'h00, 8'h05, 8'h00);
    no_resp();
  endtask

  // judge the held allocation outputs and one counter
  task automatic buf_chk(input logic tx, input logic [7:0] tr, input logic [17:0] ad,
      input logic [13:0] cn, input logic [7:0] off, input logic [15:0] cnt);
    logic [31:0] v;
    rd(off, v);
    chk(v[15:0], cnt);
    chk(buf_tx, tx);
    chk(buf_trib, tr);
    chk(buf_addr, ad);
    chk(buf_count, cn);
  endtask

  task automatic t_buf();
    int p;
    logic [31:0] v;
    p = pulses;
    wr(`SCAD_OFF_CTRL, 32'h0000_0001);
    cmd(8'h00, 8'h00, 8'h34, 8'h12, 8'hFF, 8'hFF);
    buf_chk(1'b0, 8'h00, 18'h3_1234, 14'h3FFF, `SCAD_OFF_POOL_CNT, 16'h0001);
    cmd(8'h04, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00);
    buf_chk(1'b1, 8'h01, 18'h0_0001, 14'h0001, `SCAD_OFF_TX_CNT, 16'h0001);
    cmd(8'h00, 8'h05, 8'h00, 8'hFF, 8'h00, 8'h41);
    buf_chk(1'b0, 8'h05, 18'h1_FF00, 14'h0100, `SCAD_OFF_PRIV_CNT, 16'h0001);
    chk(pulses, p + 3);
    cmd(8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
    // a start while the error is unread must be ignored, so no pulse follows
    wr(`SCAD_OFF_TRIB, 32'h0000_0001);
    wr(`SCAD_OFF_GO, 32'h0000_0001);
    resp(`SCAD_RESP_CTRL, 8'h00, {8'h00, `SCAD_ERR_TX_ZERO});
    cmd(8'h00, 8'h03, 8'h10, 8'h00, 8'h00, 8'hC0);
    resp(`SCAD_RESP_CTRL, 8'h03, {8'h00, `SCAD_ERR_CNT_ZERO});
    wr(`SCAD_OFF_CTRL, 32'h0000_0000);
    cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
    resp(`SCAD_RESP_CTRL, 8'h00, {8'h00, `SCAD_ERR_POOL_OFF});
    cmd(8'h02, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00);
    resp(`SCAD_RESP_CTRL, 8'h01, {8'h00, `SCAD_ERR_BAD_TYPE});
    rd(`SCAD_OFF_POOL_CNT, v);
    chk(v[15:0], 16'h0001);
    chk(pulses, p + 3);
  endtask

  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence; both response readies stay high so no answer is ever held off
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    wstrb = 4'h1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_slot();
    t_keys();
    t_buf();
    summarize();
  end

  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
